// *** rtl/cbu_branch_unit.sv ***
// conditional relative branch unit with an axi4-lite register slave
// assumes one clock aclk, synchronous active-low reset, one master
//
// Summary of operation
// - signed-not-less branch taken only when n xor v is 0
// - signed-less branch taken only when n xor v is 1
// - half-carry-set branch taken only when h is 1
// - half-carry-clear branch taken only when h is 0
// - transfer-bit-set branch taken only when t is 1
// - transfer-bit-clear branch taken only when t is 0
// - overflow-set branch taken only when v is 1
// - taken: pc = pc + offset + 1, flags kept, 2 cycles; not taken: pc = pc + 1 in 1 cycle
module cbu_branch_unit
  import cbu_pkg::*;
#(
  parameter int PC_W = 16,
  parameter int OFS_W = 7
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import cbu_pkg::*;

  localparam logic [PC_W-1:0] PC_ONE = PC_W'(1);

  cbu_state_e st;
  cbu_cond_e cond;
  cbu_flags_s flags;
  logic [PC_W-1:0] pc;
  logic [PC_W-1:0] target;
  logic [OFS_W-1:0] ofs;
  logic taken;
  logic [1:0] cycles;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // write channel: address and data latched in either order
  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire = s_axi_wvalid && s_axi_wready;
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire busy = (st != CBU_IDLE);
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;

  // write decode, byte lane 0 carries cond, flags and offset, lane 1 the go bit; pc ignores the strobes
  wire wr_ctrl = do_write && (aw_addr == CBU_CTRL_OFF);
  wire wr_flags = do_write && (aw_addr == CBU_FLAGS_OFF) && w_strb[0];
  wire wr_pc = do_write && (aw_addr == CBU_PC_OFF);
  wire wr_ofs = do_write && (aw_addr == CBU_OFS_OFF) && w_strb[0];
  wire wr_hit = (aw_addr == CBU_CTRL_OFF) || (aw_addr == CBU_FLAGS_OFF)
    || (aw_addr == CBU_PC_OFF) || (aw_addr == CBU_OFS_OFF)
    || (aw_addr == CBU_STAT_OFF);
  wire go = wr_ctrl && w_strb[1] && w_data[CBU_CTRL_GO_BIT] && !busy;

  // condition evaluation against the held flags
  wire n_xor_v = flags.n ^ flags.v;
  logic cond_ok;
  always_comb
  begin
    unique case (cond)
      CBU_SIGNED_NOT_LESS: cond_ok = !n_xor_v;
      CBU_SIGNED_LESS: cond_ok = n_xor_v;
      CBU_HALF_CARRY_SET: cond_ok = flags.h;
      CBU_HALF_CARRY_CLEAR: cond_ok = !flags.h;
      CBU_TRANSFER_SET: cond_ok = flags.t;
      CBU_TRANSFER_CLEAR: cond_ok = !flags.t;
      CBU_OVERFLOW_SET: cond_ok = flags.v;
      default: cond_ok = 1'b0; // unused code never branches
    endcase
  end

  // displacement widened with its sign before the add
  wire [PC_W-1:0] ofs_ext = {{(PC_W-OFS_W){ofs[OFS_W-1]}}, ofs};
  wire [PC_W-1:0] next_seq = pc + PC_ONE;
  wire [PC_W-1:0] next_target = pc + ofs_ext + PC_ONE;

  // read mux, unmapped words read zero with slverr
  wire rd_hit = (s_axi_araddr == CBU_CTRL_OFF) || (s_axi_araddr == CBU_FLAGS_OFF)
    || (s_axi_araddr == CBU_PC_OFF) || (s_axi_araddr == CBU_OFS_OFF)
    || (s_axi_araddr == CBU_STAT_OFF);
  wire [31:0] rd_ctrl = 32'(cond) << CBU_CTRL_COND_LSB;
  wire [31:0] rd_flags = {28'h0000000, flags};
  wire [31:0] rd_pc = 32'(pc);
  wire [31:0] rd_ofs = 32'(ofs);
  wire [31:0] rd_stat = (32'(busy) << CBU_STAT_BUSY_BIT)
    | (32'(taken) << CBU_STAT_TAKEN_BIT) | (32'(cycles) << CBU_STAT_CYC_LSB);
  wire [31:0] next_rdata =
    (s_axi_araddr == CBU_CTRL_OFF) ? rd_ctrl :
    (s_axi_araddr == CBU_FLAGS_OFF) ? rd_flags :
    (s_axi_araddr == CBU_PC_OFF) ? rd_pc :
    (s_axi_araddr == CBU_OFS_OFF) ? rd_ofs :
    (s_axi_araddr == CBU_STAT_OFF) ? rd_stat : 32'h00000000;
  assign s_axi_arready = !s_axi_rvalid;

  // write address and data holding
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end
    else
    begin
      if (aw_fire)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      else if (do_write)
        aw_held <= 1'b0;
      if (w_fire)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      else if (do_write)
        w_held <= 1'b0;
    end
  end

  // write response, one cycle after both halves are in
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= CBU_RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? CBU_RESP_OKAY : CBU_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // read response, data registered at the address handshake
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= CBU_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= rd_hit ? CBU_RESP_OKAY : CBU_RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // setup registers; frozen while busy so flags cannot move mid-branch
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cond <= cbu_cond_e'(CBU_COND_RST);
      flags <= CBU_FLAGS_RST;
      ofs <= CBU_OFS_RST;
    end
    else if (!busy)
    begin
      if (wr_ctrl && w_strb[0])
        cond <= cbu_cond_e'(w_data[CBU_CTRL_COND_LSB +: 3]);
      if (wr_flags)
        flags <= w_data[3:0];
      if (wr_ofs)
        ofs <= w_data[OFS_W-1:0];
    end
  end

  // branch sequencer: eval is cycle one, take is cycle two
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st <= CBU_IDLE;
      pc <= PC_W'(CBU_PC_RST);
      target <= PC_W'(CBU_PC_RST);
      taken <= 1'b0;
      cycles <= 2'h0;
    end
    else
    begin
      unique case (st)
        CBU_IDLE:
        begin
          if (wr_pc)
            pc <= w_data[PC_W-1:0];
          if (go)
            st <= CBU_EVAL;
        end
        CBU_EVAL:
        begin
          taken <= cond_ok;
          if (cond_ok)
          begin
            target <= next_target;
            st <= CBU_TAKE;
          end
          else
          begin
            pc <= next_seq;
            cycles <= CBU_CYC_NOT_TAKEN;
            st <= CBU_IDLE;
          end
        end
        CBU_TAKE:
        begin
          pc <= target;
          cycles <= CBU_CYC_TAKEN;
          st <= CBU_IDLE;
        end
      endcase
    end
  end

  // checks on the branch decision and its timing
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_ge_decision: assert property (
    (st == CBU_EVAL && cond == CBU_SIGNED_NOT_LESS)
      |=> (st == CBU_TAKE) == !($past(flags.n) ^ $past(flags.v)))
    else $error("signed-not-less decision wrong");

  a_lt_decision: assert property (
    (st == CBU_EVAL && cond == CBU_SIGNED_LESS)
      |=> taken == ($past(flags.n) ^ $past(flags.v)))
    else $error("signed-less decision wrong");

  a_hs_decision: assert property (
    (st == CBU_EVAL && cond == CBU_HALF_CARRY_SET && !flags.h)
      |=> st == CBU_IDLE && pc == $past(pc) + PC_ONE)
    else $error("half-carry-set branched with h clear");

  a_hc_decision: assert property (
    (st == CBU_EVAL && cond == CBU_HALF_CARRY_CLEAR)
      |=> taken == !$past(flags.h))
    else $error("half-carry-clear decision wrong");

  a_ts_decision: assert property (
    (st == CBU_EVAL && cond == CBU_TRANSFER_SET && flags.t)
      |=> st == CBU_TAKE ##1 st == CBU_IDLE)
    else $error("transfer-set did not branch");

  a_tc_decision: assert property (
    (st == CBU_EVAL && cond == CBU_TRANSFER_CLEAR)
      |=> taken == !$past(flags.t))
    else $error("transfer-clear decision wrong");

  a_vs_decision: assert property (
    (st == CBU_EVAL && cond == CBU_OVERFLOW_SET)
      |=> taken == $past(flags.v))
    else $error("overflow-set decision wrong");

  a_taken_target: assert property (
    (st == CBU_EVAL && cond_ok)
      |=> ##1 pc == $past(pc, 2) + $past(ofs_ext, 2) + PC_ONE && cycles == CBU_CYC_TAKEN)
    else $error("taken branch target or time wrong");

  a_flags_frozen: assert property (
    go |=> $stable(flags) [*2])
    else $error("flags moved during a branch");

  a_go_one_cycle: assert property (
    go |=> st == CBU_EVAL ##1 (st == CBU_IDLE || st == CBU_TAKE))
    else $error("branch did not run in one or two cycles");

  // judged on the computed target, so a wrong extension of either sign shows up
  a_sign_extend: assert property (
    (st == CBU_TAKE) |-> $signed(target - pc - PC_ONE) == $signed(ofs))
    else $error("offset not sign-extended");
endmodule : cbu_branch_unit

// *** rtl/cbu_pkg.sv ***
// constants, types and register map of the conditional branch unit
// assumes a 32-bit axi4-lite master and a single 100 MHz clock
package cbu_pkg;
  // byte addresses of the register words
  localparam logic [7:0] CBU_CTRL_OFF = 8'h00;
  localparam logic [7:0] CBU_FLAGS_OFF = 8'h04;
  localparam logic [7:0] CBU_PC_OFF = 8'h08;
  localparam logic [7:0] CBU_OFS_OFF = 8'h0C;
  localparam logic [7:0] CBU_STAT_OFF = 8'h10;
  // control word fields
  localparam int CBU_CTRL_COND_LSB = 0;
  localparam int CBU_CTRL_GO_BIT = 8;
  // flag word fields
  localparam int CBU_FLAG_H_BIT = 0;
  localparam int CBU_FLAG_T_BIT = 1;
  localparam int CBU_FLAG_N_BIT = 2;
  localparam int CBU_FLAG_V_BIT = 3;
  // status word fields
  localparam int CBU_STAT_BUSY_BIT = 0;
  localparam int CBU_STAT_TAKEN_BIT = 1;
  localparam int CBU_STAT_CYC_LSB = 4;
  // reset values
  localparam logic [2:0] CBU_COND_RST = 3'h0;
  localparam logic [3:0] CBU_FLAGS_RST = 4'h0;
  localparam logic [15:0] CBU_PC_RST = 16'h0000;
  localparam logic [6:0] CBU_OFS_RST = 7'h00;
  // execution times in cycles
  localparam logic [1:0] CBU_CYC_NOT_TAKEN = 2'h1;
  localparam logic [1:0] CBU_CYC_TAKEN = 2'h2;
  // axi responses
  localparam logic [1:0] CBU_RESP_OKAY = 2'h0;
  localparam logic [1:0] CBU_RESP_SLVERR = 2'h2;

  // branch conditions, code 7 is unused
  typedef enum logic [2:0] {
    CBU_SIGNED_NOT_LESS,
    CBU_SIGNED_LESS,
    CBU_HALF_CARRY_SET,
    CBU_HALF_CARRY_CLEAR,
    CBU_TRANSFER_SET,
    CBU_TRANSFER_CLEAR,
    CBU_OVERFLOW_SET
  } cbu_cond_e;

  typedef enum logic [1:0] {
    CBU_IDLE,
    CBU_EVAL,
    CBU_TAKE
  } cbu_state_e;

  // status flags seen by the unit
  typedef struct packed {
    logic v;
    logic n;
    logic t;
    logic h;
  } cbu_flags_s;
endpackage : cbu_pkg

// *** tb/cbu_tb.sv ***
// bench for the conditional branch unit: axi4-lite master, model, checks
// assumes the register map, field positions and timing of cbu_pkg
module testbench import cbu_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, got;
  logic [3:0] wstrb, fl;
  logic [1:0] bresp, rresp, resp;
  logic [15:0] seed, pc, ep;
  logic [6:0] ofs;
  logic tk;
  int num_errors, num_checks;

  cbu_branch_unit cbu_branch_unit_inst (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );

  // 100 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // pseudo-random source, fixed start
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // one write; aw and w released separately as each is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : rd

  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
    begin
      $display("No errors found");
    end
    else
    begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  // hang guard, far beyond the ~3600 cycles the tests need
  initial
  begin
    #400000;
    num_errors++;
    summarize();
  end

  // main sequence: every condition against every flag pattern
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hF;
    seed = 16'h58ED;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (int a = 0; a < 5; a++)
    begin
      rd(8'(a * 4), got, resp);
      chk(got, 32'h0);
    end
    for (int c = 0; c < 8; c++)
    begin
      for (int f = 0; f < 16; f++)
      begin
        fl = 4'(f);
        seed = lfsr(seed);
        pc = seed;
        seed = lfsr(seed);
        // extreme displacements on the edge patterns, random otherwise
        ofs = (f == 0) ? 7'h40 : (f == 15) ? 7'h3F : seed[6:0];
        wr(CBU_FLAGS_OFF, 32'(fl), resp);
        wr(CBU_PC_OFF, 32'(pc), resp);
        wr(CBU_OFS_OFF, 32'(ofs), resp);
        wr(CBU_CTRL_OFF, 32'h100 | 32'(c), resp);
        chk(32'(resp), 32'(CBU_RESP_OKAY));
        // model: h=0 t=1 n=2 v=3
        case (c)
          0: tk = ~(fl[2] ^ fl[3]);
          1: tk = fl[2] ^ fl[3];
          2: tk = fl[0];
          3: tk = ~fl[0];
          4: tk = fl[1];
          5: tk = ~fl[1];
          6: tk = fl[3];
          default: tk = 1'b0;
        endcase
        ep = pc + 16'h1 + (tk ? {{9{ofs[6]}}, ofs} : 16'h0);
        got = 32'h1;
        while (got[0]) rd(CBU_STAT_OFF, got, resp);
        chk(got, tk ? 32'h22 : 32'h10);
        rd(CBU_PC_OFF, got, resp);
        chk(got, 32'(ep));
        rd(CBU_FLAGS_OFF, got, resp);
        chk(got, 32'(fl));
        rd(CBU_CTRL_OFF, got, resp);
        chk(got, 32'(c));
      end
    end
    // unmapped place answers with an error and reads zero
    wr(8'h14, 32'hFFFFFFFF, resp);
    chk(32'(resp), 32'(CBU_RESP_SLVERR));
    rd(8'h14, got, resp);
    chk({got[29:0], resp}, 32'(CBU_RESP_SLVERR));
    summarize();
  end
endmodule : testbench
